// ---- logic/wdog_supervisor.sv ----
// watchdog timer supervisor: control register, timeout, delayed cpu reset
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`default_nettype none
`include "wdog_map.svh"
module wdog_supervisor (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // register port
  input wire logic [`WDOG_ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // cpu interrupt context
  input wire logic global_irq_en_in,
  input wire logic [1:0] irq_priority_state_in,
  input wire logic prio_higher_in,
  // outputs
  output logic irq_out,
  output logic irq_take_out,
  output logic cpu_reset_out
);
  // ==========================================
  // control register
  // ==========================================
  logic timeout_irq_en_q, timeout_irq_en_d;
  logic [1:0] interval_sel_q, interval_sel_d;
  logic timeout_irq_flag_q, timeout_irq_flag_d;
  logic reset_cause_flag_q, reset_cause_flag_d;
  logic reset_en_q, reset_en_d;
  logic restart_kick_q, restart_kick_d;
  logic [1:0] mask_q, mask_d;
  logic [1:0] stat_q, stat_d;
  logic [7:0] rdata_q, rdata_d;
  logic irq_q, irq_d;

  logic expire;
  logic reset_fire;
  logic wr_ctrl;
  logic enabled;
  logic restart;

  assign wr_ctrl = wr_in && addr_in == `WDOG_CTRL_ADDR;
  assign enabled = timeout_irq_en_q || reset_en_q;

  function automatic logic [7:0] ctrl_word(input logic ie, input logic [1:0] sel, input logic f,
                                           input logic rf, input logic re, input logic k);
    ctrl_word = '0;
    ctrl_word[`WDOG_BIT_IRQ_EN] = ie;
    ctrl_word[`WDOG_BIT_SEL_HI:`WDOG_BIT_SEL_LO] = sel;
    ctrl_word[`WDOG_BIT_IRQ_FLAG] = f;
    ctrl_word[`WDOG_BIT_RST_FLAG] = rf;
    ctrl_word[`WDOG_BIT_RST_EN] = re;
    ctrl_word[`WDOG_BIT_KICK] = k;
  endfunction

  always_comb begin
    timeout_irq_en_d = timeout_irq_en_q;
    interval_sel_d = interval_sel_q;
    timeout_irq_flag_d = timeout_irq_flag_q;
    reset_cause_flag_d = reset_cause_flag_q;
    reset_en_d = reset_en_q;
    restart_kick_d = 1'b0;
    if (wr_ctrl) begin
      timeout_irq_en_d = wdata_in[`WDOG_BIT_IRQ_EN];
      interval_sel_d = wdata_in[`WDOG_BIT_SEL_HI:`WDOG_BIT_SEL_LO];
      // flags written directly; hardware set below still wins
      timeout_irq_flag_d = wdata_in[`WDOG_BIT_IRQ_FLAG];
      reset_cause_flag_d = wdata_in[`WDOG_BIT_RST_FLAG];
      reset_en_d = wdata_in[`WDOG_BIT_RST_EN];
      restart_kick_d = wdata_in[`WDOG_BIT_KICK];
    end
    if (expire) begin
      timeout_irq_flag_d = 1'b1;
    end
    if (reset_fire) begin
      reset_cause_flag_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      timeout_irq_en_q <= 1'b0;
      interval_sel_q <= 2'h0;
      timeout_irq_flag_q <= 1'b0;
      reset_cause_flag_q <= 1'b0;
      reset_en_q <= 1'b0;
      restart_kick_q <= 1'b0;
    end else begin
      timeout_irq_en_q <= timeout_irq_en_d;
      interval_sel_q <= interval_sel_d;
      timeout_irq_flag_q <= timeout_irq_flag_d;
      reset_cause_flag_q <= reset_cause_flag_d;
      reset_en_q <= reset_en_d;
      restart_kick_q <= restart_kick_d;
    end
  end

  // ==========================================
  // event status, mask and interrupt line
  // ==========================================
  // status bits are sticky: an event in the clearing cycle survives the clear
  always_comb begin
    mask_d = mask_q;
    stat_d = stat_q;
    if (wr_in && addr_in == `WDOG_MASK_ADDR) begin
      mask_d = wdata_in[`WDOG_EV_W-1:0];
    end
    if (wr_in && addr_in == `WDOG_STAT_ADDR) begin
      stat_d = stat_q & ~wdata_in[`WDOG_EV_W-1:0];
    end
    if (expire) begin
      stat_d[`WDOG_EV_TIMEOUT] = 1'b1;
    end
    if (reset_fire) begin
      stat_d[`WDOG_EV_RESET] = 1'b1;
    end
    irq_d = |(stat_q & mask_q);
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      mask_q <= 2'h0;
      stat_q <= 2'h0;
      irq_q <= 1'b0;
    end else begin
      mask_q <= mask_d;
      stat_q <= stat_d;
      irq_q <= irq_d;
    end
  end

  // ==========================================
  // read-back
  // ==========================================
  // data are zero between reads so a stale word is never taken for an answer
  always_comb begin
    rdata_d = '0;
    if (rd_in) begin
      unique case (addr_in)
        `WDOG_CTRL_ADDR: rdata_d = ctrl_word(timeout_irq_en_q, interval_sel_q, timeout_irq_flag_q,
                                             reset_cause_flag_q, reset_en_q, restart_kick_q);
        `WDOG_MASK_ADDR: rdata_d = {6'h00, mask_q};
        `WDOG_STAT_ADDR: rdata_d = {6'h00, stat_q};
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rdata_q <= `WDOG_CTRL_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================
  // sequencer
  // ==========================================
  wdog_pkg::wd_state_e state_q, state_d;
  logic [1:0] start_q, start_d;
  logic [9:0] pend_q, pend_d;
  logic [3:0] hold_q, hold_d;
  logic cpu_reset_q, cpu_reset_d;
  logic run;

  // setting reset enable restarts only if interrupt enable was clear
  assign restart = restart_kick_q ||
                   (wr_ctrl && wdata_in[`WDOG_BIT_RST_EN] && !reset_en_q && !timeout_irq_en_q);
  assign run = state_q == wdog_pkg::ST_RUN;

  always_comb begin
    state_d = state_q;
    start_d = start_q;
    pend_d = pend_q;
    reset_fire = 1'b0;
    unique case (state_q)
      wdog_pkg::ST_OFF: begin
        pend_d = '0;
        start_d = '0;
        if (enabled) begin
          state_d = wdog_pkg::ST_START;
        end
      end
      wdog_pkg::ST_START: begin
        // enable capture plus this two-clock wait gives three clocks before counting
        start_d = start_q + 2'h1;
        if (start_q == `WDOG_START_DELAY - 2'h1) begin
          state_d = wdog_pkg::ST_RUN;
        end
      end
      wdog_pkg::ST_RUN: begin
        if (expire && reset_en_q) begin
          pend_d = `WDOG_RST_DELAY - 10'h1;
          state_d = wdog_pkg::ST_PEND;
        end
      end
      wdog_pkg::ST_PEND: begin
        pend_d = pend_q - 10'h1;
        if (restart || !reset_en_q) begin
          state_d = wdog_pkg::ST_RUN;
        end else if (pend_q == 10'h0) begin
          reset_fire = 1'b1;
          state_d = wdog_pkg::ST_RUN;
        end
      end
      default: state_d = wdog_pkg::ST_OFF;
    endcase
    if (!enabled) begin
      state_d = wdog_pkg::ST_OFF;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_q <= wdog_pkg::ST_OFF;
      start_q <= 2'h0;
      pend_q <= 10'h0;
    end else begin
      state_q <= state_d;
      start_q <= start_d;
      pend_q <= pend_d;
    end
  end

  // ==========================================
  // reset pulse
  // ==========================================
  // the pulse runs out even if the watchdog is disabled meanwhile, so the cpu never sees a stub
  always_comb begin
    hold_d = hold_q;
    cpu_reset_d = 1'b0;
    if (hold_q != 4'h0) begin
      hold_d = hold_q - 4'h1;
      cpu_reset_d = 1'b1;
    end
    if (reset_fire) begin
      hold_d = `WDOG_RST_LEN;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      hold_q <= 4'h0;
      cpu_reset_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
      cpu_reset_q <= cpu_reset_d;
    end
  end

  // ==========================================
  // submodules
  // ==========================================
  // divider only advances in the run and pending states: a stopped chain is the gated clock
  wdog_divider u_div (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .run_in(run || state_q == wdog_pkg::ST_PEND),
    .clear_in(restart || !enabled),
    .sel_in(interval_sel_q),
    .expire_out(expire)
  );

  wdog_irq_gate u_gate (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .req_in(timeout_irq_flag_q && timeout_irq_en_q),
    .global_irq_en_in(global_irq_en_in),
    .irq_priority_state_in(irq_priority_state_in),
    .prio_higher_in(prio_higher_in),
    .take_out(irq_take_out)
  );

  assign rdata_out = rdata_q;
  assign irq_out = irq_q;
  assign cpu_reset_out = cpu_reset_q;
endmodule
`default_nettype wire

// ---- logic/wdog_map.svh ----
// register map, field positions and timing counts of the watchdog supervisor
`ifndef WDOG_MAP_SVH
`define WDOG_MAP_SVH
`define WDOG_ADDR_W 4
`define WDOG_CTRL_ADDR 4'h0
`define WDOG_MASK_ADDR 4'h1
`define WDOG_STAT_ADDR 4'h2
`define WDOG_BIT_IRQ_EN 6
`define WDOG_BIT_SEL_HI 5
`define WDOG_BIT_SEL_LO 4
`define WDOG_BIT_IRQ_FLAG 3
`define WDOG_BIT_RST_FLAG 2
`define WDOG_BIT_RST_EN 1
`define WDOG_BIT_KICK 0
`define WDOG_CTRL_RESET 8'h00
`define WDOG_DIV_W 24
`define WDOG_TAP0 14
`define WDOG_TAP_STEP 3
`define WDOG_RST_DELAY 10'h200
`define WDOG_RST_LEN 4'h8
`define WDOG_START_DELAY 2'h2
`define WDOG_IPS_IDLE 2'h3
`define WDOG_EV_TIMEOUT 0
`define WDOG_EV_RESET 1
`define WDOG_EV_W 2
`endif

// ---- logic/wdog_pkg.sv ----
// types shared by the watchdog supervisor files
`default_nettype none
package wdog_pkg;
  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_START = 4'h2,
    ST_RUN = 4'h4,
    ST_PEND = 4'h8
  } wd_state_e;
endpackage
`default_nettype wire

// ---- logic/wdog_divider.sv ----
// divider chain, cleared while stopped, with a selectable expiry tap
`default_nettype none
`include "wdog_map.svh"
module wdog_divider (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // control
  input wire logic run_in,
  input wire logic clear_in,
  input wire logic [1:0] sel_in,
  // expiry
  output logic expire_out
);
  logic [`WDOG_DIV_W-1:0] cnt_q, cnt_d;
  logic expire_q, expire_d;

  // tap index for a select code: each step is eight times longer
  function automatic logic [4:0] tap_of(input logic [1:0] s);
    tap_of = 5'(`WDOG_TAP0 + `WDOG_TAP_STEP * s);
  endfunction

  always_comb begin
    cnt_d = cnt_q;
    expire_d = 1'b0;
    if (clear_in || !run_in) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + 1'b1;
      // all-ones below and at the tap means 2^(tap+1) clocks elapsed
      expire_d = &(cnt_q | ~((`WDOG_DIV_W'(2) << tap_of(sel_in)) - 1'b1));
      if (expire_d) begin
        cnt_d = '0;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cnt_q <= '0;
      expire_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      expire_q <= expire_d;
    end
  end

  assign expire_out = expire_q;
endmodule
`default_nettype wire

// ---- logic/wdog_irq_gate.sv ----
// interrupt acceptance gate toward the cpu
`default_nettype none
`include "wdog_map.svh"
module wdog_irq_gate (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // conditions
  input wire logic req_in,
  input wire logic global_irq_en_in,
  input wire logic [1:0] irq_priority_state_in,
  input wire logic prio_higher_in,
  // result
  output logic take_out
);
  logic take_q, take_d;

  always_comb begin
    take_d = req_in && global_irq_en_in &&
             (irq_priority_state_in == `WDOG_IPS_IDLE || prio_higher_in);
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      take_q <= 1'b0;
    end else begin
      take_q <= take_d;
    end
  end

  assign take_out = take_q;
endmodule
`default_nettype wire

// ---- test/wdog_supervisor_props.sv ----
// port-level assertions for the watchdog supervisor
`default_nettype none
`include "wdog_map.svh"
module wdog_supervisor_props (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // register port
  input wire logic [`WDOG_ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  // cpu context
  input wire logic global_irq_en_in,
  input wire logic [1:0] irq_priority_state_in,
  input wire logic prio_higher_in,
  // outputs
  input wire logic irq_out,
  input wire logic irq_take_out,
  input wire logic cpu_reset_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // shadow enables, since the checker cannot see the register
  logic cw;
  logic ien_q, ien_d, ren_q, ren_d;
  assign cw = wr_in && addr_in == `WDOG_CTRL_ADDR;
  always_comb begin
    ien_d = cw ? wdata_in[`WDOG_BIT_IRQ_EN] : ien_q;
    ren_d = cw ? wdata_in[`WDOG_BIT_RST_EN] : ren_q;
  end
  always_ff @(posedge mclk_in) begin
    ien_q <= reset_in ? 1'h0 : ien_d;
    ren_q <= reset_in ? 1'h0 : ren_d;
  end
  // ==========
  // properties
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);
  a_reset_len: assert property ($rose(cpu_reset_out) |-> cpu_reset_out [*8] ##1 !cpu_reset_out)
    else $error("cpu reset length wrong");
  a_reset_gap: assert property ($fell(cpu_reset_out) |-> !cpu_reset_out [*8])
    else $error("cpu reset repeated too soon");
  a_reset_needs_en: assert property ($rose(cpu_reset_out) |-> $past(ren_q))
    else $error("cpu reset without reset enable");
  a_off_quiet: assert property (cw && !wdata_in[6] && !wdata_in[1] |-> ##2 (!$rose(cpu_reset_out)) [*8])
    else $error("reset raised while disabled");
  a_take_cond: assert property (irq_take_out |-> $past(global_irq_en_in) &&
    ($past(irq_priority_state_in) == `WDOG_IPS_IDLE || $past(prio_higher_in)))
    else $error("interrupt taken against cpu state");
  a_take_needs_en: assert property (irq_take_out |-> $past(ien_q))
    else $error("interrupt taken while disabled");
  a_kick_self_clear: assert property (rd_in && addr_in == `WDOG_CTRL_ADDR && !$past(wr_in)
    |=> !rdata_out[`WDOG_BIT_KICK])
    else $error("restart bit stuck");
  a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside read slot");
endmodule
`default_nettype wire

// ---- test/test_wdog_supervisor.sv ----
// self-checking bench for the watchdog supervisor
`default_nettype none
`include "wdog_map.svh"
module test_wdog_supervisor;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in, reset_in, wr_in, rd_in, gie, ph, irq_out, irq_take_out, cpu_reset_out;
  logic [`WDOG_ADDR_W-1:0] addr;
  logic [7:0] wdata, rdata_out, v;
  logic [1:0] ips;
  int error_cnt, checks, n;
  wdog_supervisor i_dut (.mclk_in(mclk_in), .reset_in(reset_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .global_irq_en_in(gie), .irq_priority_state_in(ips),
    .prio_higher_in(ph), .irq_out(irq_out), .irq_take_out(irq_take_out), .cpu_reset_out(cpu_reset_out));
  initial begin
    mclk_in = 1'h0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  // ==========
  // shared tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    wr_in <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge mclk_in);
    wr_in <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk_in);
    rd_in <= 1'h1;
    addr <= a;
    @(posedge mclk_in);
    rd_in <= 1'h0;
    #1;
    v = rdata_out;
  endtask
  // waits are bounded so a dead block still ends the run
  task automatic wait_hi(input logic rst, input int lim);
    n = 0;
    while ((rst ? cpu_reset_out : irq_out) !== 1'h1 && n < lim) begin
      @(posedge mclk_in);
      #1;
      n++;
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_regs();
    rd(`WDOG_CTRL_ADDR);
    chk(v, `WDOG_CTRL_RESET);
    wr(`WDOG_CTRL_ADDR, 8'h31);
    rd(`WDOG_CTRL_ADDR);
    chk(v, 8'h30);
    rd(4'hF);
    chk(v, 8'h00);
    wr(`WDOG_CTRL_ADDR, 8'h00);
    $display("register test done");
  endtask
  task automatic t_irq();
    gie <= 1'h1;
    ips <= `WDOG_IPS_IDLE;
    wr(`WDOG_MASK_ADDR, 8'h01);
    wr(`WDOG_CTRL_ADDR, 8'h40);
    // a kick part-way must push the timeout a full interval past the kick
    repeat (8000) @(posedge mclk_in);
    wr(`WDOG_CTRL_ADDR, 8'h41);
    wait_hi(1'h0, 40000);
    chk(32'(n >= 32768 && n <= 32776), 32'h1);
    @(posedge mclk_in);
    ips <= 2'h0;
    #1;
    chk(irq_take_out, 1'h1);
    repeat (3) @(posedge mclk_in);
    ph <= 1'h1;
    #1;
    chk(irq_take_out, 1'h0);
    repeat (3) @(posedge mclk_in);
    #1;
    chk(irq_take_out, 1'h1);
    repeat (600) @(posedge mclk_in);
    chk(cpu_reset_out, 1'h0);
    rd(`WDOG_CTRL_ADDR);
    chk(v, 8'h48);
    rd(`WDOG_STAT_ADDR);
    chk(v, 8'h01);
    wr(`WDOG_STAT_ADDR, 8'h01);
    wr(`WDOG_CTRL_ADDR, 8'h40);
    rd(`WDOG_CTRL_ADDR);
    chk(v, 8'h40);
    chk(irq_out, 1'h0);
    wr(`WDOG_CTRL_ADDR, 8'h00);
    gie <= 1'h0;
    $display("interrupt test done");
  endtask
  task automatic t_rst();
    wr(`WDOG_CTRL_ADDR, 8'h40);
    repeat (8000) @(posedge mclk_in);
    // interrupt enable already set: arming the reset must not restart the count
    wr(`WDOG_CTRL_ADDR, 8'h42);
    wait_hi(1'h1, 40000);
    chk(32'(n >= 25278 && n <= 25288), 32'h1);
    n = 0;
    while (cpu_reset_out === 1'h1 && n < 20) begin
      @(posedge mclk_in);
      #1;
      n++;
    end
    chk(n, 8);
    rd(`WDOG_CTRL_ADDR);
    chk(v & 8'h0E, 8'h0E);
    rd(`WDOG_STAT_ADDR);
    chk(v, 8'h03);
    wr(`WDOG_CTRL_ADDR, 8'h00);
    rd(`WDOG_CTRL_ADDR);
    chk(v, 8'h00);
    $display("reset test done");
  endtask
  initial begin
    reset_in = 1'h1;
    wr_in = 1'h0;
    rd_in = 1'h0;
    addr = 4'h0;
    wdata = 8'h00;
    gie = 1'h0;
    ips = 2'h0;
    ph = 1'h0;
    repeat (6) @(posedge mclk_in);
    reset_in <= 1'h0;
    t_regs();
    t_irq();
    t_rst();
    stop_test();
  end
  initial begin
    repeat (90000) @(posedge mclk_in);
    error_cnt++;
    stop_test();
  end
endmodule
bind wdog_supervisor wdog_supervisor_props i_props (.mclk_in(mclk_in), .reset_in(reset_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .global_irq_en_in(global_irq_en_in),
  .irq_priority_state_in(irq_priority_state_in), .prio_higher_in(prio_higher_in), .irq_out(irq_out),
  .irq_take_out(irq_take_out), .cpu_reset_out(cpu_reset_out));
`default_nettype wire
